// *** shared/spc_map.svh ***
// Address map, field positions, reset values and counts of the serial port configuration block
// How it works
// - Bit 7 low, the default: two-way data pin carries reads; separate output floats.
// - Bit 7 high: read data leaves on separate output; writes still use two-way pin.
// - Bit 6 low, the default: shift most significant bit first, address steps down.
// - Bit 6 high: shift least significant bit first, address steps up.
// - In I2C mode bit 6 is ignored; I2C order and ascending addresses apply.
// - Writing 1 to bit 5 restores all register defaults; the bit clears itself.
// - Bit 0 of 0x004 picks readback bank: 0 buffer, 1 active.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPC_ADDR_W 13
`define SPC_ADDR_CFG 13'h000
`define SPC_ADDR_RBK 13'h004

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPC_CFG_SEP_BIT 7
`define SPC_CFG_LSB_BIT 6
`define SPC_CFG_SRST_BIT 5
`define SPC_RBK_SEL_BIT 0
`define SPC_INSTR_RW_BIT 15
`define SPC_INSTR_ADDR_MSB 12

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SPC_SEP_RST 1'h0
`define SPC_LSB_RST 1'h0
`define SPC_RBK_RST 1'h0
`define SPC_SCLK_IDLE 1'h1
`define SPC_INSTR_LAST 4'hf
`define SPC_BYTE_LAST 4'h7
`define SPC_SYNC_RST 4'hd

`endif

// *** shared/spc_pkg.sv ***
// Types shared by the serial port configuration block
package spc_pkg;

	typedef enum logic [1:0] {
		SPC_IDLE,
		SPC_INSTR,
		SPC_DATA
	} spc_state_t;

	typedef struct packed {
		logic sep_out;
		logic lsb_asc;
	} spc_mode_t;

	typedef struct packed {
		logic stb;
		logic [12:0] addr;
		logic [7:0] data;
	} spc_wr_t;

endpackage

// *** verilog/spc_sync.sv ***
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module spc_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					meta_q <= RST_VAL[i];
					sync_q <= RST_VAL[i];
				end else begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate
endmodule // spc_sync

// *** verilog/spc_regs.sv ***
// Serial port configuration registers with their serial front end
`timescale 1ns/10ps
`include "spc_map.svh"
module spc_regs (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SDIO_I,
	input wire logic I2C_MODE,
	input wire logic [7:0] RD_BUF_DATA,
	input wire logic [7:0] RD_ACT_DATA,
	output logic SDIO_O,
	output logic SDIO_OE,
	output logic SDO_O,
	output logic SDO_OE,
	output logic [12:0] RD_ADDR,
	output spc_pkg::spc_wr_t WR,
	output logic SOFT_RESET,
	output spc_pkg::spc_mode_t MODE,
	output logic READBACK_ACTIVE
);

	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	logic [3:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic sdio_s;
	logic i2c_s;
	logic sclk_prev_q;
	logic sclk_rise;
	logic sclk_fall;

	spc_sync #(
		.W(4),
		.RST_VAL(`SPC_SYNC_RST)
	) u_sync (
		.CLK(CLK),
		.RST_N(RST_N),
		.d({CS_N, SCLK, SDIO_I, I2C_MODE}),
		.q(pins_s)
	);

	assign cs_n_s = pins_s[3];
	assign sclk_s = pins_s[2];
	assign sdio_s = pins_s[1];
	assign i2c_s = pins_s[0];

	// Reset to the idle level so release of reset shows no false rising edge
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sclk_prev_q <= `SPC_SCLK_IDLE;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic sep_out_q;
	logic lsb_first_ascend_q;
	logic readback_bank_select_q;
	logic soft_reset_q;
	spc_pkg::spc_mode_t act_q;
	spc_pkg::spc_wr_t wr_q;
	logic lsb_eff;
	logic asc_eff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sep_out_q <= `SPC_SEP_RST;
			lsb_first_ascend_q <= `SPC_LSB_RST;
			readback_bank_select_q <= `SPC_RBK_RST;
			soft_reset_q <= 1'h0;
		end else begin
			soft_reset_q <= 1'h0;
			if (wr_q.stb && wr_q.addr == `SPC_ADDR_CFG) begin
				// Mirror nibble is not checked; it only guards against wrong orientation
				if (wr_q.data[`SPC_CFG_SRST_BIT]) begin
					sep_out_q <= `SPC_SEP_RST;
					lsb_first_ascend_q <= `SPC_LSB_RST;
					readback_bank_select_q <= `SPC_RBK_RST;
					soft_reset_q <= 1'h1;
				end else begin
					sep_out_q <= wr_q.data[`SPC_CFG_SEP_BIT];
					lsb_first_ascend_q <= wr_q.data[`SPC_CFG_LSB_BIT];
				end
			end else if (wr_q.stb && wr_q.addr == `SPC_ADDR_RBK) begin
				readback_bank_select_q <= wr_q.data[`SPC_RBK_SEL_BIT];
			end
		end
	end

	// Mode in force only changes between frames so a running transfer keeps its framing
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			act_q.sep_out <= `SPC_SEP_RST;
			act_q.lsb_asc <= `SPC_LSB_RST;
		end else if (cs_n_s) begin
			act_q.sep_out <= sep_out_q;
			act_q.lsb_asc <= lsb_first_ascend_q;
		end
	end

	assign lsb_eff = act_q.lsb_asc & ~i2c_s;
	assign asc_eff = act_q.lsb_asc | i2c_s;

	// ----------------------------------------------------------------
	// Serial frame: 16-bit instruction, then bytes until chip select rises
	// ----------------------------------------------------------------
	spc_pkg::spc_state_t state_q;
	logic [15:0] sr_q;
	logic [15:0] instr_d;
	logic [7:0] byte_d;
	logic [3:0] cnt_q;
	logic rw_q;
	logic [12:0] addr_q;
	logic load_q;

	always_comb begin
		if (lsb_eff) begin
			instr_d = {sdio_s, sr_q[15:1]};
			byte_d = {sdio_s, sr_q[7:1]};
		end else begin
			instr_d = {sr_q[14:0], sdio_s};
			byte_d = {sr_q[6:0], sdio_s};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= spc_pkg::SPC_IDLE;
			sr_q <= 16'h0000;
			cnt_q <= 4'h0;
			rw_q <= 1'h0;
			addr_q <= `SPC_ADDR_CFG;
			load_q <= 1'h0;
			wr_q <= '0;
		end else begin
			load_q <= 1'h0;
			wr_q.stb <= 1'h0;
			if (cs_n_s) begin
				state_q <= spc_pkg::SPC_IDLE;
				cnt_q <= 4'h0;
			end else begin
				unique case (state_q)
					spc_pkg::SPC_IDLE: begin
						state_q <= spc_pkg::SPC_INSTR;
						cnt_q <= 4'h0;
					end
					spc_pkg::SPC_INSTR: begin
						if (sclk_rise) begin
							sr_q <= instr_d;
							cnt_q <= cnt_q + 4'h1;
							if (cnt_q == `SPC_INSTR_LAST) begin
								rw_q <= instr_d[`SPC_INSTR_RW_BIT];
								addr_q <= instr_d[`SPC_INSTR_ADDR_MSB:0];
								load_q <= instr_d[`SPC_INSTR_RW_BIT];
								cnt_q <= 4'h0;
								state_q <= spc_pkg::SPC_DATA;
							end
						end
					end
					spc_pkg::SPC_DATA: begin
						if (sclk_rise) begin
							sr_q <= {8'h00, byte_d};
							cnt_q <= cnt_q + 4'h1;
							if (cnt_q == `SPC_BYTE_LAST) begin
								cnt_q <= 4'h0;
								load_q <= rw_q;
								if (!rw_q) begin
									wr_q.stb <= 1'h1;
									wr_q.addr <= addr_q;
									wr_q.data <= byte_d;
								end
								if (asc_eff) begin
									addr_q <= addr_q + 13'h0001;
								end else begin
									addr_q <= addr_q - 13'h0001;
								end
							end
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	logic [7:0] cfg_rd;
	logic [7:0] rd_byte;
	logic [7:0] tx_q;
	logic out_bit_q;
	logic driving;

	// Soft reset bit always reads 0; low nibble shows the mirrored image
	assign cfg_rd = {sep_out_q, lsb_first_ascend_q, 1'h0, 1'h0,
		1'h0, 1'h0, lsb_first_ascend_q, sep_out_q};

	always_comb begin
		if (addr_q == `SPC_ADDR_CFG) begin
			rd_byte = cfg_rd;
		end else if (addr_q == `SPC_ADDR_RBK) begin
			rd_byte = {7'h00, readback_bank_select_q};
		end else if (readback_bank_select_q) begin
			rd_byte = RD_ACT_DATA;
		end else begin
			rd_byte = RD_BUF_DATA;
		end
	end

	// Byte loads right after the last rising edge, ahead of the next falling edge
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_q <= 8'h00;
			out_bit_q <= 1'h0;
		end else if (load_q) begin
			tx_q <= rd_byte;
		end else if (sclk_fall && state_q == spc_pkg::SPC_DATA && rw_q) begin
			if (lsb_eff) begin
				out_bit_q <= tx_q[0];
				tx_q <= {1'h0, tx_q[7:1]};
			end else begin
				out_bit_q <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'h0};
			end
		end
	end

	assign driving = (state_q == spc_pkg::SPC_DATA) && rw_q && !cs_n_s;
	assign SDIO_OE = driving && !act_q.sep_out;
	assign SDO_OE = driving && act_q.sep_out;
	assign SDIO_O = out_bit_q;
	assign SDO_O = out_bit_q;

	assign RD_ADDR = addr_q;
	assign WR = wr_q;
	assign SOFT_RESET = soft_reset_q;
	assign MODE = act_q;
	assign READBACK_ACTIVE = readback_bank_select_q;

endmodule // spc_regs

// *** test/spc_regs_properties.sv ***
// Checker for the serial port configuration registers
`timescale 1ns/10ps
`include "spc_map.svh"
module spc_regs_properties (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SDIO_OE,
	input wire logic SDO_OE,
	input spc_pkg::spc_wr_t WR,
	input wire logic SOFT_RESET,
	input spc_pkg::spc_mode_t MODE,
	input wire logic READBACK_ACTIVE
);
	logic srst_wr;
	logic rbk_wr;
	assign srst_wr = WR.stb && WR.addr == `SPC_ADDR_CFG && WR.data[`SPC_CFG_SRST_BIT];
	assign rbk_wr = WR.stb && WR.addr == `SPC_ADDR_RBK;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Mode may trail the pins by a few cycles at frame end
	a_sdo_float: assert property (SDO_OE |-> MODE.sep_out || $past(MODE.sep_out, 4))
		else $error("separate output driven in shared pin mode");
	a_sdio_write_only: assert property (SDIO_OE |-> !MODE.sep_out || !$past(MODE.sep_out, 4))
		else $error("two-way pin driven in separate output mode");
	a_srst_pulse: assert property (SOFT_RESET |=> !SOFT_RESET)
		else $error("soft reset did not clear itself");
	a_srst_cause: assert property (SOFT_RESET |-> srst_wr || $past(srst_wr))
		else $error("soft reset without a write of bit 5");
	a_srst_clear: assert property (srst_wr |=> !READBACK_ACTIVE)
		else $error("soft reset left readback select set");
	a_rbk_load: assert property (rbk_wr |=> READBACK_ACTIVE == $past(WR.data[`SPC_RBK_SEL_BIT]))
		else $error("readback select not loaded");
	a_rbk_cause: assert property ($changed(READBACK_ACTIVE) |-> $past(rbk_wr) || $past(srst_wr))
		else $error("readback select changed without a write");
	a_mode_idle: assert property ($changed(MODE) |-> $past(CS_N, 3) || $past(srst_wr))
		else $error("mode changed inside a transfer");
endmodule // spc_regs_properties

bind spc_regs spc_regs_properties u_props (.CLK, .RST_N, .CS_N, .SDIO_OE, .SDO_OE, .WR,
	.SOFT_RESET, .MODE, .READBACK_ACTIVE);

// *** test/spc_host.sv ***
// Host controller model for the serial port
`timescale 1ns/10ps
module spc_host (
	output logic cs_n,
	output logic sclk,
	output logic sd,
	input wire logic rx
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		sd = 1'b0;
	end
	// Data moves while the clock is low; the device samples on the rise
	task automatic frame(input logic [15:0] ins, input logic [15:0] dat, input int nb,
		input logic lsb, output logic [15:0] rd);
		logic [31:0] v;
		logic [31:0] r;
		int i;
		v = {dat, ins};
		r = '0;
		#37 cs_n = 1'b0;
		#400;
		for (int k = 0; k < 16 + 8 * nb; k++) begin
			i = (k < 16) ? (lsb ? k : 15 - k) : 16 + 8 * ((k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
			sclk = 1'b0;
			sd = v[i];
			#400;
			r[i] = rx;
			sclk = 1'b1;
			#400;
		end
		cs_n = 1'b1;
		#1200;
		rd = r[31:16];
	endtask
endmodule // spc_host

// *** test/tb_top.sv ***
// Self-checking bench for the serial port configuration registers
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic i2c = 1'b0;
	logic sep = 1'b0;
	logic [7:0] buf_d = 8'h00;
	logic [7:0] act_d = 8'h00;
	logic cs_n, sclk, sd, sdio_o, sdio_oe, sdo_o, sdo_oe, srst, rba;
	logic [12:0] rd_addr;
	spc_pkg::spc_wr_t wr;
	spc_pkg::spc_mode_t mode;
	logic [20:0] wq[$];
	int n_errors = 0;
	int tests_run = 0;
	int n_srst = 0;
	wire sdio = sdio_oe ? sdio_o : sd;
	wire rx = sep ? (sdo_oe ? sdo_o : 1'bz) : sdio;
	always #50 clk = ~clk;
	spc_host host (.cs_n(cs_n), .sclk(sclk), .sd(sd), .rx(rx));
	spc_regs uut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SDIO_I(sdio),
		.I2C_MODE(i2c), .RD_BUF_DATA(buf_d), .RD_ACT_DATA(act_d), .SDIO_O(sdio_o),
		.SDIO_OE(sdio_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .RD_ADDR(rd_addr), .WR(wr),
		.SOFT_RESET(srst), .MODE(mode), .READBACK_ACTIVE(rba));
	task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] s);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Low nibble must be the bit-reversed upper nibble
	function automatic logic [15:0] cfg(input logic [3:0] u);
		return {8'h00, u, u[0], u[1], u[2], u[3]};
	endfunction
	task automatic wrt(input logic [12:0] a, input logic [15:0] d, input int nb, input logic lsb);
		logic [15:0] r;
		for (int b = 0; b < nb; b++)
			wq.push_back({13'(a + ((i2c || lsb) ? b : -b)), d[8*b+:8]});
		host.frame({3'b000, a}, d, nb, lsb, r);
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		logic [15:0] r;
		host.frame({3'b100, a}, 16'($urandom), 1, 1'b0, r);
		chk("read", {13'h0, e}, {13'h0, r[7:0]});
	endtask
	// Sampled mid-cycle so the one-cycle strobe is seen settled, exactly once
	always @(negedge clk) begin
		if (wr.stb)
			chk("write", wq.size() ? wq.pop_front() : '1, wr[20:0]);
	end
	always @(negedge clk) begin
		if (srst)
			n_srst++;
	end
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#3000000;
		n_errors++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'h9ce2));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		buf_d <= 8'($urandom);
		act_d <= 8'($urandom);
		repeat (6) @(posedge clk);
		chk("mode", '0, {mode, rba});
		rd(13'h000, 8'h00);
		rd(13'h155, buf_d);
		chk("addr", 21'h154, {8'h00, rd_addr});
		wrt(13'h004, 16'h0001, 1, 1'b0);
		rd(13'h155, act_d);
		$display("test readback done");
		wrt(13'h031, 16'h2211, 2, 1'b0);
		wrt(13'h000, cfg(4'h8), 1, 1'b0);
		chk("mode", 21'h5, {mode, rba});
		sep = 1'b1;
		rd(13'h000, 8'h81);
		wrt(13'h000, cfg(4'h4), 1, 1'b0);
		chk("mode", 21'h3, {mode, rba});
		sep = 1'b0;
		$display("test pin mode done");
		wrt(13'h020, 16'hb3a7, 2, 1'b1);
		@(posedge clk) i2c <= 1'b1;
		repeat (4) @(posedge clk);
		wrt(13'h040, 16'h5c6d, 2, 1'b0);
		chk("addr", 21'h42, {8'h00, rd_addr});
		@(posedge clk) i2c <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test order done");
		wrt(13'h000, cfg(4'h2), 1, 1'b1);
		chk("mode", '0, {mode, rba});
		chk("soft reset", 21'h1, 21'(n_srst));
		chk("queue", '0, 21'(wq.size()));
		$display("test soft reset done");
		print_verdict;
	end
endmodule // tb_top
